// *** logic/smcit_pkg.sv ***
// Purpose: shared constants and carriers for the integration test register bank
// Assumes: 32-bit configuration port, word registers, offsets decoded on 13 bits
// Notes: input and output carriers are packed to match the register bit layout
package smcit_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_TEST_CONTROL = 13'h1E00;
  localparam logic [ADDR_W-1:0] OFS_INPUT_READBACK = 13'h1E04;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_DRIVE = 13'h1E08;
  localparam logic [ADDR_W-1:0] OFS_PERIPH_ID3 = 13'h1FEC;

  localparam int BIT_TEST_EN = 0;
  localparam int BIT_INTEG_CFG = 0;
  localparam int HTRANS_ACTIVE_BIT = 1;

  localparam logic TEST_CONTROL_RESET = 1'h0;
  localparam logic INTEG_CFG_PRESENT = 1'h1;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // bit 5 down to bit 0 of the input readback word
  typedef struct packed {
    logic mem_clock_sync_tie;
    logic bus_clock_sync_tie;
    logic shared_bus_backoff;
    logic shared_bus_grant;
    logic use_shared_bus;
    logic csysreq;
  } smcit_inputs_t;

  localparam int INPUT_W = $bits(smcit_inputs_t);

  // bit 2 down to bit 0 of the output drive word
  typedef struct packed {
    logic shared_bus_request;
    logic csysack;
    logic cactive;
  } smcit_outputs_t;

  localparam int OUTPUT_W = $bits(smcit_outputs_t);
  localparam logic [OUTPUT_W-1:0] OUTPUT_DRIVE_RESET = 3'h0;

endpackage

// *** logic/smcit_sync2.sv ***
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs are quasi-static or slow relative to clk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module smcit_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end

endmodule

// *** logic/smcit_top.sv ***
// Purpose: integration test register bank on the configuration AHB port
// Assumes: zero-wait-state slave, single clock clk_i, async active-low reset
// Notes: reserved and write-only bits read as zero; unmapped offsets read zero
`timescale 1ns/1ps
// Overview of operation
// - control bit 0 resets low; when set, test drive replaces functional outputs
// - no access is possible while reset is held; software waits for release
// - input readback bit 5 memory-sync tie, bit 4 bus-sync tie
// - input readback bits 3,2,1 show backoff, grant and use-shared-bus inputs
// - input readback bit 0 shows low-power request; bits 31:6 read zero
// - input readback is read-only; writes to it are ignored
// - in test mode drive bit 2 sets the shared bus request output
// - in test mode drive bit 1 sets the low-power acknowledge output
// - in test mode drive bit 0 sets the controller-active output
// - identification register 3 bit 0 reads one: test registers are present
module smcit_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  input wire logic mem_clock_sync_tie_i,
  input wire logic bus_clock_sync_tie_i,
  input wire logic shared_bus_backoff_i,
  input wire logic shared_bus_grant_i,
  input wire logic use_shared_bus_i,
  input wire logic csysreq_i,
  input wire logic func_shared_bus_request_i,
  input wire logic func_csysack_i,
  input wire logic func_cactive_i,
  output logic shared_bus_request_o,
  output logic csysack_o,
  output logic cactive_o,
  output logic test_mode_o
);

  // synchronised pin levels
  smcit_pkg::smcit_inputs_t pins_raw;
  smcit_pkg::smcit_inputs_t pins_sync;

  assign pins_raw.mem_clock_sync_tie = mem_clock_sync_tie_i;
  assign pins_raw.bus_clock_sync_tie = bus_clock_sync_tie_i;
  assign pins_raw.shared_bus_backoff = shared_bus_backoff_i;
  assign pins_raw.shared_bus_grant = shared_bus_grant_i;
  assign pins_raw.use_shared_bus = use_shared_bus_i;
  assign pins_raw.csysreq = csysreq_i;

  smcit_sync2 #(
    .WIDTH(smcit_pkg::INPUT_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .d_i(pins_raw),
    .q_o(pins_sync)
  );

  // address phase decode
  logic [smcit_pkg::ADDR_W-1:0] addr_ofs;
  logic addr_take;
  logic rd_take;
  logic wr_take;

  assign addr_ofs = haddr_i[smcit_pkg::ADDR_W-1:0];
  assign addr_take = hsel_i & htrans_i[smcit_pkg::HTRANS_ACTIVE_BIT] & hready_i;
  assign rd_take = addr_take & ~hwrite_i;
  assign wr_take = addr_take & hwrite_i;

  // pending write, completed in its data phase
  logic wr_pend;
  logic [smcit_pkg::ADDR_W-1:0] wr_addr;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'h0;
      wr_addr <= '0;
    end else if (hready_i) begin
      wr_pend <= wr_take;
      wr_addr <= addr_ofs;
    end
  end

  logic wr_done;
  logic wr_control;
  logic wr_drive;

  assign wr_done = wr_pend & hready_i;
  assign wr_control = wr_done & (wr_addr == smcit_pkg::OFS_TEST_CONTROL);
  // readback register has no write path
  assign wr_drive = wr_done & (wr_addr == smcit_pkg::OFS_OUTPUT_DRIVE);

  // test control and output drive registers
  logic test_en;
  logic next_test_en;
  smcit_pkg::smcit_outputs_t drive;
  smcit_pkg::smcit_outputs_t next_drive;

  // control stores bit 0 and drive stores bits 2:0; upper bits are expected zero from software
  assign next_test_en = wr_control ? hwdata_i[smcit_pkg::BIT_TEST_EN] : test_en;
  assign next_drive = wr_drive ? hwdata_i[smcit_pkg::OUTPUT_W-1:0] : drive;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      test_en <= smcit_pkg::TEST_CONTROL_RESET;
      drive <= smcit_pkg::OUTPUT_DRIVE_RESET;
    end else begin
      test_en <= next_test_en;
      drive <= next_drive;
    end
  end

  // read data, registered at the end of the address phase
  logic [31:0] rd_control;
  logic [31:0] rd_inputs;
  logic [31:0] rd_id3;
  logic [31:0] rd_word;

  // forward a write completing now so back-to-back reads see it
  assign rd_control = {31'h0000_0000, next_test_en};
  assign rd_inputs = {26'h000_0000, pins_sync};
  assign rd_id3 = {31'h0000_0000, smcit_pkg::INTEG_CFG_PRESENT};

  // drive register is write-only and reads as zero
  assign rd_word = (addr_ofs == smcit_pkg::OFS_TEST_CONTROL) ? rd_control :
                   (addr_ofs == smcit_pkg::OFS_INPUT_READBACK) ? rd_inputs :
                   (addr_ofs == smcit_pkg::OFS_PERIPH_ID3) ? rd_id3 :
                   smcit_pkg::READ_ZERO;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= smcit_pkg::READ_ZERO;
      hreadyout_o <= 1'h1;
      hresp_o <= smcit_pkg::HRESP_OKAY;
    end else begin
      hrdata_o <= rd_take ? rd_word : smcit_pkg::READ_ZERO;
      hreadyout_o <= 1'h1;
      hresp_o <= smcit_pkg::HRESP_OKAY;
    end
  end

  // output selection between functional logic and test drive
  smcit_pkg::smcit_outputs_t func_out;
  smcit_pkg::smcit_outputs_t pin_sel;

  assign func_out.shared_bus_request = func_shared_bus_request_i;
  assign func_out.csysack = func_csysack_i;
  assign func_out.cactive = func_cactive_i;
  assign pin_sel = test_en ? drive : func_out;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shared_bus_request_o <= 1'h0;
      csysack_o <= 1'h0;
      cactive_o <= 1'h0;
      test_mode_o <= smcit_pkg::TEST_CONTROL_RESET;
    end else begin
      shared_bus_request_o <= pin_sel.shared_bus_request;
      csysack_o <= pin_sel.csysack;
      cactive_o <= pin_sel.cactive;
      test_mode_o <= test_en;
    end
  end

endmodule

// *** test/smcit_checker.sv ***
// Purpose: port checks for the integration test bank
// Assumes: zero-wait config port, pins lag one flop
// Notes: bound from the bench top
`timescale 1ns/1ps
module smcit_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic [1:0] hresp_o,
  input wire logic func_shared_bus_request_i,
  input wire logic func_csysack_i,
  input wire logic func_cactive_i,
  input wire logic shared_bus_request_o,
  input wire logic csysack_o,
  input wire logic cactive_o,
  input wire logic test_mode_o
);
  wire logic rd = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  wire logic wr = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  wire logic [12:0] a = haddr_i[12:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ready_okay_a: assert property (hreadyout_o && hresp_o == 2'h0) else $error("ready");
  active_func_a: assert property ($past(reset_n_i) && !test_mode_o |->
    cactive_o == $past(func_cactive_i)) else $error("cactive");
  ack_func_a: assert property ($past(reset_n_i) && !test_mode_o |->
    csysack_o == $past(func_csysack_i)) else $error("csysack");
  req_func_a: assert property ($past(reset_n_i) && !test_mode_o |->
    shared_bus_request_o == $past(func_shared_bus_request_i)) else $error("req");
  idle_zero_a: assert property ($past(reset_n_i) && !$past(rd) |->
    hrdata_o == 32'h0) else $error("idle data");
  id_bit_a: assert property ($past(rd && a == 13'h1FEC) |->
    hrdata_o == 32'h1) else $error("id bit");
  drive_hidden_a: assert property ($past(rd && a == 13'h1E08) |->
    hrdata_o == 32'h0) else $error("drive read");
  ctrl_write_a: assert property ($past(wr && a == 13'h1E00, 3) |->
    test_mode_o == $past(hwdata_i[0], 2)) else $error("enable");
endmodule

// *** test/smcit_master.sv ***
// Purpose: config bus master for the integration bank
// Assumes: one transfer at a time
// Notes: released write data shows the inverse word
`timescale 1ns/1ps
module smcit_master (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o
);
  initial {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel_o <= 1'h1;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    haddr_o <= {19'h0, a};
    @(posedge clk_i);
    while (hready_i !== 1'h1) @(posedge clk_i);
    hsel_o <= 1'h0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge clk_i);
    // data phase ends at the edge that samples ready high
    while (hready_i !== 1'h1) @(posedge clk_i);
    q = hrdata_i;
    hwdata_o <= ~d;
  endtask
endmodule

// *** test/smcit_top_test.sv ***
// Purpose: self-checking bench for the integration test bank
// Assumes: pins pass two flops before readback
// Notes: model holds enable and drive in integers
`timescale 1ns/1ps
module smcit_top_test;
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic hsel, hwrite, rdy, tmo;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, hresp;
  logic [5:0] pin = 6'h0;
  logic [2:0] fn = 3'h0;
  logic [2:0] po;
  int num_errors = 0, compares = 0, cyc = 0, tm = 0, drv = 0;
  int unsigned rs = 67;
  always #5 clk_i = ~clk_i;
  smcit_master i_smcit_master (.clk_i(clk_i), .hready_i(rdy), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  smcit_top i_smcit_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hwdata_i(hwdata),
    .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp),
    .mem_clock_sync_tie_i(pin[5]), .bus_clock_sync_tie_i(pin[4]),
    .shared_bus_backoff_i(pin[3]), .shared_bus_grant_i(pin[2]), .use_shared_bus_i(pin[1]),
    .csysreq_i(pin[0]), .func_shared_bus_request_i(fn[2]), .func_csysack_i(fn[1]),
    .func_cactive_i(fn[0]), .shared_bus_request_o(po[2]), .csysack_o(po[1]),
    .cactive_o(po[0]), .test_mode_o(tmo));
  function automatic int unsigned nx(int unsigned x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    i_smcit_master.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [12:0] a, input logic [31:0] e);
    i_smcit_master.xfer(1'h0, a, 32'h0, q);
    check(q, e);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    rd(13'h1E00, 32'h0);
    rd(13'h1FEC, 32'h1);
    rd(13'h0100, 32'h0);
    for (int i = 0; i < 24; i++) begin
      rs = nx(rs);
      pin <= rs[5:0];
      fn <= rs[8:6];
      drv = rs[11:9];
      tm = rs[12];
      wr(13'h1E08, drv);
      wr(13'h1E00, tm);
      wr(13'h1E04, rs);
      rd(13'h1E04, {26'h0, rs[5:0]});
      rd(13'h1E08, 32'h0);
      rd(13'h1E00, tm);
      repeat (2) @(posedge clk_i);
      #1 check({29'h0, po}, {29'h0, tm ? drv[2:0] : rs[8:6]});
      check({31'h0, tmo}, tm);
      @(posedge clk_i);
    end
    print_verdict();
  end
endmodule
bind smcit_top smcit_checker i_smcit_checker (.*);
